// >>> rtl/amon_chan.sv
// Purpose: One analog monitor channel: select, scale, offset, negate, clip
// Assumes: Inputs are synchronous to hclk
// Notes: Output code updates one edge after any input or setting changes
`timescale 1ns/1ps
module amon_chan
  import amon_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic [15:0] sel,
  input logic signed [15:0] mag,
  input logic signed [15:0] offs,
  input amon_src_s src,
  output logic signed [15:0] code,
  output logic beyond
);
  amon_chan_s r, n;
  amon_calc_t sel_mv, prod, sum;

  function automatic amon_calc_t scl(input logic signed [31:0] v,
                                     input int k);
    return amon_calc_t'(v) * amon_calc_t'(k);
  endfunction

  always_comb begin
    sel_mv = '0;
    unique case (sel[AMON_SEL_W-1:0])
      AMON_SEL_MOTOR_SPEED: sel_mv = scl(src.motor_speed, AMON_MV_PER_RPM); // see RL2
      AMON_SEL_SPEED_REF: sel_mv = scl(src.speed_ref, AMON_MV_PER_RPM); // see RL2
      AMON_SEL_POS_REF_SPEED: sel_mv = scl(src.pos_ref_speed, AMON_MV_PER_RPM); // see RL2
      AMON_SEL_SPEED_FF: sel_mv = scl(src.speed_ff, AMON_MV_PER_RPM); // see RL2
      AMON_SEL_EXT_ENC_SPEED: sel_mv = scl(src.ext_enc_speed, AMON_MV_PER_RPM); // see RL2
      AMON_SEL_TORQUE_REF: sel_mv = scl(src.torque_ref, AMON_MV_PER_TRQ); // see RL3
      AMON_SEL_TORQUE_FF: sel_mv = scl(src.torque_ff, AMON_MV_PER_TRQ); // see RL3
      AMON_SEL_POS_ERR: begin
        // Speed or torque control shows no position error
        if (src.pos_ctrl) begin
          sel_mv = scl(src.pos_err, AMON_MV_PER_PERR); // see RL4
        end
      end
      AMON_SEL_POS_AMP_ERR: sel_mv = scl(src.pos_amp_err, AMON_MV_PER_PULSE); // see RL5
      AMON_SEL_LOAD_POS_ERR: sel_mv = scl(src.load_pos_err, AMON_MV_PER_LERR); // see RL6
      AMON_SEL_POSN_DONE: sel_mv = src.posn_done ? amon_calc_t'(AMON_MV_DONE) : '0; // see RL7
      AMON_SEL_REF_DONE: sel_mv = src.ref_done ? amon_calc_t'(AMON_MV_DONE) : '0; // see RL7
      AMON_SEL_ACTIVE_GAIN: begin
        sel_mv = src.gain2_active ? amon_calc_t'(AMON_MV_GAIN2)
                                  : amon_calc_t'(AMON_MV_GAIN1); // see RL8
      end
      // Reserved and undefined codes output only the offset
      default: sel_mv = '0; // see RL9
    endcase
    // Wide enough that no product or sum can wrap before clipping
    prod = sel_mv * amon_calc_t'(mag) / amon_calc_t'(AMON_MAG_UNITY); // see RL10
    sum = -(prod + amon_calc_t'(offs) * amon_calc_t'(AMON_MV_PER_OFF)); // see RL10
    n.code = amon_sat16(sum); // see RL13, RL14
    n.beyond = (sum > amon_calc_t'(AMON_MV_LINEAR)) ||
               (sum < -amon_calc_t'(AMON_MV_LINEAR)); // see RL13
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign code = r.code;
  assign beyond = r.beyond;
endmodule

// >>> rtl/amon_top.sv
// Purpose: Two-channel analog monitor source select and scaling, AHB-Lite
// Assumes: Single word transfers; monitored quantities on hclk
// Notes: Zero wait states; output codes are millivolts, two's complement
`timescale 1ns/1ps
// Function
// RL1: Channel one follows its own select, channel two its own, independently.
// RL2: Codes 00,01,05,09,0D give speeds at 1 V per 1000 rpm.
// RL3: Codes 02 and 0A give torque at 1 V per 100 % rated.
// RL4: Code 03 gives position error, 0.05 V/unit, zero outside position control.
// RL5: Code 04 gives position amplifier error at 0.05 V per pulse.
// RL6: Code 07 gives motor-to-load position error at 0.01 V per unit.
// RL7: Codes 08 and 0C give 5 V when completed, else 0 V.
// RL8: Code 0B gives 1 V for first gain set, 2 V for second.
// RL9: Software must not program reserved code 06.
// RL10: Output is minus the sum of scaled signal and offset.
// RL11: Offset setting spans -10000 to 10000 in 0.1 V, default 0.
// RL12: Magnification spans -10000 to 10000 in 0.01, default 100.
// RL13: Output code is 16 bits; linear range is eight volts each way.
// RL14: Results beyond the 16-bit range clip at the nearest limit.
module amon_top
  import amon_pkg::*;
#(
  parameter int DEC_W = 8
)
(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input amon_src_s src,
  output logic signed [15:0] monitor1_dac_code,
  output logic signed [15:0] monitor2_dac_code,
  output logic monitor1_beyond,
  output logic monitor2_beyond
);
  if (DEC_W < 6 || DEC_W > 8) begin : g_chk
    $error("amon_top: DEC_W must be 6 to 8");
  end

  amon_regs_s r, n;
  logic accept;
  logic [7:0] a_addr;
  logic mapped;

  // Transfer size is not checked: only whole words are ever issued
  assign accept = hsel && hready && htrans[1];
  assign a_addr = 8'(haddr[DEC_W-1:0]);
  assign mapped = (haddr[31:DEC_W] == '0);

  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                        input amon_regs_s s,
                                        input logic [15:0] c1,
                                        input logic [15:0] c2,
                                        input logic b1,
                                        input logic b2);
    logic [31:0] d;
    d = '0;
    unique case (a)
      AMON_OFS_SEL1: d = {16'h0000, s.sel1};
      AMON_OFS_SEL2: d = {16'h0000, s.sel2};
      AMON_OFS_OFF1: d = {16'h0000, s.off1};
      AMON_OFS_OFF2: d = {16'h0000, s.off2};
      AMON_OFS_MAG1: d = {16'h0000, s.mag1};
      AMON_OFS_MAG2: d = {16'h0000, s.mag2};
      AMON_OFS_CODE1: d = {16'h0000, c1};
      AMON_OFS_CODE2: d = {16'h0000, c2};
      AMON_OFS_STAT: d = {30'h00000000, b2, b1};
      default: d = '0;
    endcase
    return d;
  endfunction

  always_comb begin
    n = r;
    n.ap_wr = accept && hwrite && mapped;
    n.ap_addr = a_addr;
    // Data phase: store the word, new settings act on the next edge
    if (r.ap_wr) begin
      unique case (r.ap_addr)
        AMON_OFS_SEL1: n.sel1 = hwdata[15:0]; // see RL1
        AMON_OFS_SEL2: n.sel2 = hwdata[15:0]; // see RL1
        AMON_OFS_OFF1: n.off1 = amon_clamp_set(hwdata[15:0]); // see RL11
        AMON_OFS_OFF2: n.off2 = amon_clamp_set(hwdata[15:0]); // see RL11
        AMON_OFS_MAG1: n.mag1 = amon_clamp_set(hwdata[15:0]); // see RL12
        AMON_OFS_MAG2: n.mag2 = amon_clamp_set(hwdata[15:0]); // see RL12
        default: n.sel1 = r.sel1;
      endcase
    end
    // Reading from the updated copy forwards a write just completed
    n.rdata = '0;
    if (accept && !hwrite && mapped) begin
      n.rdata = rd_mux(a_addr, n, monitor1_dac_code, monitor2_dac_code,
                       monitor1_beyond, monitor2_beyond);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.sel1 <= AMON_SEL1_RST; // see RL3
      r.sel2 <= AMON_SEL2_RST; // see RL2
      r.off1 <= AMON_OFF_RST; // see RL11
      r.off2 <= AMON_OFF_RST; // see RL11
      r.mag1 <= AMON_MAG_RST; // see RL12
      r.mag2 <= AMON_MAG_RST; // see RL12
      r.ap_wr <= 1'b0;
      r.ap_addr <= '0;
      r.rdata <= '0;
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  amon_chan u_ch1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(r.sel1),
    .mag(r.mag1),
    .offs(r.off1),
    .src(src),
    .code(monitor1_dac_code),
    .beyond(monitor1_beyond)
  );

  amon_chan u_ch2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(r.sel2),
    .mag(r.mag2),
    .offs(r.off2),
    .src(src),
    .code(monitor2_dac_code),
    .beyond(monitor2_beyond)
  );

  // Checks
  logic ch1_plain, ch2_plain;
  assign ch1_plain = (r.mag1 == AMON_MAG_RST) && (r.off1 == AMON_OFF_RST);
  assign ch2_plain = (r.mag2 == AMON_MAG_RST) && (r.off2 == AMON_OFF_RST);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_sel_indep;
    r.ap_wr && (r.ap_addr == AMON_OFS_SEL2) |=> $stable(r.sel1);
  endproperty
  a_sel_indep: assert property (p_sel_indep) // see RL1
    else $error("select two write disturbed select one");

  property p_speed;
    ch2_plain && (r.sel2[7:0] == 8'h00) |=>
      monitor2_dac_code == amon_sat16(-amon_calc_t'($past(src.motor_speed)));
  endproperty
  a_speed: assert property (p_speed) // see RL2
    else $error("motor speed scaling wrong");

  property p_torque;
    ch1_plain && (r.sel1[7:0] == 8'h02) |=>
      monitor1_dac_code == amon_sat16(-amon_calc_t'($past(src.torque_ref)));
  endproperty
  a_torque: assert property (p_torque) // see RL3
    else $error("torque reference scaling wrong");

  property p_pos_err_zero;
    (r.sel1[7:0] == 8'h03) && (r.off1 == AMON_OFF_RST) && !src.pos_ctrl
      |=> monitor1_dac_code == 16'h0000;
  endproperty
  a_pos_err_zero: assert property (p_pos_err_zero) // see RL4
    else $error("position error not zero outside position control");

  property p_amp_err;
    ch2_plain && (r.sel2[7:0] == 8'h04) |=>
      monitor2_dac_code == amon_sat16(-amon_calc_t'($past(src.pos_amp_err))
                                      * amon_calc_t'(AMON_MV_PER_PULSE));
  endproperty
  a_amp_err: assert property (p_amp_err) // see RL5
    else $error("position amplifier error scaling wrong");

  property p_load_err;
    ch1_plain && (r.sel1[7:0] == 8'h07) |=>
      monitor1_dac_code == amon_sat16(-amon_calc_t'($past(src.load_pos_err))
                                      * amon_calc_t'(AMON_MV_PER_LERR));
  endproperty
  a_load_err: assert property (p_load_err) // see RL6
    else $error("load position error scaling wrong");

  property p_done;
    ch1_plain && (r.sel1[7:0] == 8'h08) && src.posn_done
      |=> monitor1_dac_code == 16'(-AMON_MV_DONE);
  endproperty
  a_done: assert property (p_done) // see RL7
    else $error("positioning completed level wrong");

  property p_gain;
    ch2_plain && (r.sel2[7:0] == 8'h0b) |=>
      monitor2_dac_code == ($past(src.gain2_active) ? 16'(-AMON_MV_GAIN2)
                                                   : 16'(-AMON_MV_GAIN1));
  endproperty
  a_gain: assert property (p_gain) // see RL8
    else $error("active gain level wrong");

  property p_offset;
    (r.sel1[7:0] == 8'h0c) && !src.ref_done ##1 $stable(r.off1) |->
      monitor1_dac_code == amon_sat16(-amon_calc_t'($signed($past(r.off1)))
                                      * amon_calc_t'(AMON_MV_PER_OFF));
  endproperty
  a_offset: assert property (p_offset) // see RL10
    else $error("offset not applied with negation");

  property p_mag_now;
    r.ap_wr && (r.ap_addr == AMON_OFS_MAG1) |=>
      r.mag1 == amon_clamp_set($past(hwdata[15:0])) ##1
      $signed(r.mag1) <= $signed(16'(AMON_SET_MAX));
  endproperty
  a_mag_now: assert property (p_mag_now) // see RL12
    else $error("magnification write not taken at once");

  property p_off_now;
    r.ap_wr && (r.ap_addr == AMON_OFS_OFF2) |=>
      r.off2 == amon_clamp_set($past(hwdata[15:0]));
  endproperty
  a_off_now: assert property (p_off_now) // see RL11
    else $error("offset write not taken at once");

  property p_clip;
    (r.sel2[7:0] == 8'h00) && (r.off2 == AMON_OFF_RST) &&
    ($signed(r.mag2) == 16'(AMON_SET_MAX)) && (src.motor_speed > 1000)
      |=> monitor2_dac_code == 16'(AMON_CODE_MIN) && monitor2_beyond;
  endproperty
  a_clip: assert property (p_clip) // see RL14
    else $error("output wrapped instead of clipping");

  property p_linear;
    monitor1_beyond == ((int'(monitor1_dac_code) > AMON_MV_LINEAR) ||
                        (int'(monitor1_dac_code) < -AMON_MV_LINEAR));
  endproperty
  a_linear: assert property (p_linear) // see RL13
    else $error("linear range flag disagrees with code");

  property p_read_sel;
    accept && !hwrite && mapped && (a_addr == AMON_OFS_SEL1) && !r.ap_wr
      |=> hrdata == {16'h0000, $past(r.sel1)};
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("select read data wrong");

  c_clip: cover property (p_clip);
  c_write_mag: cover property (r.ap_wr && r.ap_addr == AMON_OFS_MAG1);
  c_pos_zero: cover property ((r.sel1[7:0] == 8'h03) && !src.pos_ctrl);
  c_gain2: cover property ((r.sel2[7:0] == 8'h0b) && src.gain2_active);
endmodule

// >>> shared/amon_pkg.sv
// Purpose: Shared constants, types and helpers of the analog monitor block
// Assumes: Output code is signed, one LSB per millivolt
// Notes: Monitored quantities arrive already in the units named below
package amon_pkg;
  // Register byte offsets
  localparam logic [7:0] AMON_OFS_SEL1 = 8'h00;
  localparam logic [7:0] AMON_OFS_SEL2 = 8'h04;
  localparam logic [7:0] AMON_OFS_OFF1 = 8'h08;
  localparam logic [7:0] AMON_OFS_OFF2 = 8'h0c;
  localparam logic [7:0] AMON_OFS_MAG1 = 8'h10;
  localparam logic [7:0] AMON_OFS_MAG2 = 8'h14;
  localparam logic [7:0] AMON_OFS_CODE1 = 8'h18;
  localparam logic [7:0] AMON_OFS_CODE2 = 8'h1c;
  localparam logic [7:0] AMON_OFS_STAT = 8'h20;
  // Reset values
  localparam logic [15:0] AMON_SEL1_RST = 16'h0002;
  localparam logic [15:0] AMON_SEL2_RST = 16'h0000;
  localparam logic [15:0] AMON_OFF_RST = 16'h0000;
  localparam logic [15:0] AMON_MAG_RST = 16'h0064;
  // Setting range and scales
  localparam int AMON_SET_MIN = -10000;
  localparam int AMON_SET_MAX = 10000;
  localparam int AMON_MAG_UNITY = 100;
  localparam int AMON_MV_PER_OFF = 100;
  localparam int AMON_MV_PER_RPM = 1;
  localparam int AMON_MV_PER_TRQ = 1;
  localparam int AMON_MV_PER_PERR = 50;
  localparam int AMON_MV_PER_PULSE = 50;
  localparam int AMON_MV_PER_LERR = 10;
  localparam int AMON_MV_DONE = 5000;
  localparam int AMON_MV_GAIN1 = 1000;
  localparam int AMON_MV_GAIN2 = 2000;
  localparam int AMON_MV_LINEAR = 8000;
  localparam int AMON_CODE_MAX = 32767;
  localparam int AMON_CODE_MIN = -32768;
  localparam int AMON_SEL_W = 8;

  typedef enum logic [7:0] {
    AMON_SEL_MOTOR_SPEED = 8'h00,
    AMON_SEL_SPEED_REF = 8'h01,
    AMON_SEL_TORQUE_REF = 8'h02,
    AMON_SEL_POS_ERR = 8'h03,
    AMON_SEL_POS_AMP_ERR = 8'h04,
    AMON_SEL_POS_REF_SPEED = 8'h05,
    AMON_SEL_RESERVED = 8'h06,
    AMON_SEL_LOAD_POS_ERR = 8'h07,
    AMON_SEL_POSN_DONE = 8'h08,
    AMON_SEL_SPEED_FF = 8'h09,
    AMON_SEL_TORQUE_FF = 8'h0a,
    AMON_SEL_ACTIVE_GAIN = 8'h0b,
    AMON_SEL_REF_DONE = 8'h0c,
    AMON_SEL_EXT_ENC_SPEED = 8'h0d
  } amon_sel_e;

  typedef logic signed [63:0] amon_calc_t;

  // Speeds in rpm, torques in 0.1 % rated, errors in reference units/pulses
  typedef struct packed {
    logic signed [31:0] motor_speed;
    logic signed [31:0] speed_ref;
    logic signed [31:0] pos_ref_speed;
    logic signed [31:0] speed_ff;
    logic signed [31:0] ext_enc_speed;
    logic signed [31:0] torque_ref;
    logic signed [31:0] torque_ff;
    logic signed [31:0] pos_err;
    logic signed [31:0] pos_amp_err;
    logic signed [31:0] load_pos_err;
    logic pos_ctrl;
    logic posn_done;
    logic ref_done;
    logic gain2_active;
  } amon_src_s;

  typedef struct packed {
    logic signed [15:0] code;
    logic beyond;
  } amon_chan_s;

  typedef struct packed {
    logic [15:0] sel1;
    logic [15:0] sel2;
    logic [15:0] off1;
    logic [15:0] off2;
    logic [15:0] mag1;
    logic [15:0] mag2;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } amon_regs_s;

  function automatic logic signed [15:0] amon_sat16(input amon_calc_t v);
    if (v > amon_calc_t'(AMON_CODE_MAX)) begin
      return 16'(AMON_CODE_MAX);
    end else if (v < amon_calc_t'(AMON_CODE_MIN)) begin
      return 16'(AMON_CODE_MIN);
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] amon_clamp_set(input logic [15:0] v);
    // Both sides signed, else a negative setting compares as a huge one
    if ($signed(v) > $signed(16'(AMON_SET_MAX))) begin
      return 16'(AMON_SET_MAX);
    end else if ($signed(v) < $signed(16'(AMON_SET_MIN))) begin
      return 16'(AMON_SET_MIN);
    end
    return v;
  endfunction
endpackage

// >>> tb/amon_instrument.sv
// Purpose: Recorder model on the analog monitor connector
// Assumes: Codes are millivolts, two's complement, sampled each edge
// Notes: Listens only; it never drives anything back into the driver
`timescale 1ns/1ps
module amon_instrument
  import amon_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic signed [15:0] monitor1_dac_code,
  input logic signed [15:0] monitor2_dac_code,
  output int reading1_mv,
  output int reading2_mv,
  output int clipped_seen
);
  // Past eight volts the recorder trace is no longer trusted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reading1_mv <= 0;
      reading2_mv <= 0;
      clipped_seen <= 0;
    end else begin
      reading1_mv <= int'(monitor1_dac_code);
      reading2_mv <= int'(monitor2_dac_code);
      if (monitor1_dac_code > 16'sd8000 || monitor1_dac_code < -16'sd8000) begin
        clipped_seen <= clipped_seen + 1;
      end
    end
  end
endmodule

// >>> tb/tb_analog_monitor_output_select.sv
// Purpose: Self-checking bench of the two-channel analog monitor block
// Assumes: Zero wait AHB-Lite slave; monitored inputs on hclk
// Notes: Reference model holds settings as integers, clamped like the block
`timescale 1ns/1ps
module tb_analog_monitor_output_select;
  import amon_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  amon_src_s src;
  logic signed [15:0] monitor1_dac_code, monitor2_dac_code;
  logic monitor1_beyond, monitor2_beyond;
  int err_total, comparisons, cycles, r1, r2, nclip;
  int m_sel[2], m_off[2], m_mag[2];
  logic [15:0] lfsr;
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [15:0] rv[6] = '{16'h0002, 16'h0000, 16'h0000, 16'h0000,
                         16'h0064, 16'h0064};
  // Code 06 is left out on purpose
  logic [7:0] codes[13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
  assign hready = hreadyout;
  amon_top #(.DEC_W(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src(src),
    .monitor1_dac_code(monitor1_dac_code),
    .monitor2_dac_code(monitor2_dac_code),
    .monitor1_beyond(monitor1_beyond), .monitor2_beyond(monitor2_beyond));
  amon_instrument i_inst (.hclk(hclk), .hresetn(hresetn),
    .monitor1_dac_code(monitor1_dac_code),
    .monitor2_dac_code(monitor2_dac_code),
    .reading1_mv(r1), .reading2_mv(r2), .clipped_seen(nclip));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles; this is a hang guard only
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic int rs(logic big);
    logic [15:0] r;
    r = rnd();
    return big ? int'($signed(r)) : int'($signed(r[11:0]));
  endfunction
  function automatic int clip(longint v, longint lo, longint hi);
    return int'(v > hi ? hi : (v < lo ? lo : v));
  endfunction
  // Entered right after a rising edge; returns right after one
  task automatic bus(logic w, logic [31:0] a, logic [31:0] wd,
                     output logic [31:0] rdv);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rdv = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    int c;
    c = clip(longint'($signed(v)), -10000, 10000);
    bus(1'b1, {24'h0, a}, {16'h0, v}, rd);
    case (a)
      AMON_OFS_SEL1: m_sel[0] = int'(v);
      AMON_OFS_SEL2: m_sel[1] = int'(v);
      AMON_OFS_OFF1: m_off[0] = c;
      AMON_OFS_OFF2: m_off[1] = c;
      AMON_OFS_MAG1: m_mag[0] = c;
      AMON_OFS_MAG2: m_mag[1] = c;
      default: ;
    endcase
  endtask
  function automatic longint sel_mv(int s);
    case (s & 255)
      0: return src.motor_speed;
      1: return src.speed_ref;
      5: return src.pos_ref_speed;
      9: return src.speed_ff;
      13: return src.ext_enc_speed;
      2: return src.torque_ref;
      10: return src.torque_ff;
      3: return src.pos_ctrl ? 50 * longint'(src.pos_err) : 0;
      4: return 50 * longint'(src.pos_amp_err);
      7: return 10 * longint'(src.load_pos_err);
      8: return src.posn_done ? 5000 : 0;
      12: return src.ref_done ? 5000 : 0;
      11: return src.gain2_active ? 2000 : 1000;
      default: return 0;
    endcase
  endfunction
  function automatic longint full_mv(int ch);
    return -((sel_mv(m_sel[ch]) * m_mag[ch]) / 100 + m_off[ch] * 100);
  endfunction
  task automatic check_out();
    longint f0, f1;
    logic b0, b1;
    f0 = full_mv(0);
    f1 = full_mv(1);
    b0 = f0 > 8000 || f0 < -8000;
    b1 = f1 > 8000 || f1 < -8000;
    chk("code1", clip(f0, -32768, 32767), 32'(monitor1_dac_code));
    chk("code2", clip(f1, -32768, 32767), 32'(monitor2_dac_code));
    chk("beyond1", 32'(b0), 32'(monitor1_beyond));
    chk("beyond2", 32'(b1), 32'(monitor2_beyond));
    chk("reading1", clip(f0, -32768, 32767), 32'(r1));
    chk("reading2", clip(f1, -32768, 32767), 32'(r2));
  endtask
  task automatic new_src(logic big, logic pc);
    amon_src_s s;
    s.motor_speed = rs(big);
    s.speed_ref = rs(big);
    s.pos_ref_speed = rs(big);
    s.speed_ff = rs(big);
    s.ext_enc_speed = rs(big);
    s.torque_ref = rs(big);
    s.torque_ff = rs(big);
    s.pos_err = rs(big);
    s.pos_amp_err = rs(big);
    s.load_pos_err = rs(big);
    s.pos_ctrl = pc;
    {s.posn_done, s.ref_done, s.gain2_active} = 3'(rnd());
    src <= s;
  endtask
  task automatic reset_model();
    m_sel = '{2, 0};
    m_off = '{0, 0};
    m_mag = '{100, 100};
  endtask
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {err_total, comparisons, cycles} = '0;
    lfsr = 16'h005c;
    src = '0;
    src.torque_ref = 32'sd1234;
    src.motor_speed = -32'sd567;
    reset_model();
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check_out();
    foreach (ra[i]) begin
      bus(1'b0, 32'(ra[i]), 32'h0, rd);
      chk("reset value", 32'(rv[i]), rd);
    end
    chk("hresp", 32'h0, 32'(hresp));
    for (int ch = 0; ch < 2; ch++) begin
      foreach (codes[k]) begin
        new_src(k[0], ch[0]);
        wr(ch ? AMON_OFS_SEL2 : AMON_OFS_SEL1, 16'(codes[k]));
        bus(1'b0, ch ? 32'h4 : 32'h0, 32'h0, rd);
        chk("select readback", 32'(codes[k]), rd);
        wr(ch ? AMON_OFS_MAG2 : AMON_OFS_MAG1, 16'(rs(0) % 201));
        wr(ch ? AMON_OFS_OFF2 : AMON_OFS_OFF1, 16'(rs(0) % 51));
        repeat (3) @(posedge hclk);
        check_out();
      end
    end
    // Out-of-range settings are clamped; the result then clips
    for (int i = 0; i < 2; i++) begin
      src.motor_speed <= (i == 0) ? 32'sd30000 : -32'sd30000;
      wr(AMON_OFS_SEL1, 16'h0000);
      wr(AMON_OFS_MAG1, 16'h7fff);
      wr(AMON_OFS_OFF1, (i == 0) ? 16'h8000 : 16'h7fff);
      wr(AMON_OFS_SEL2, 16'h0000);
      wr(AMON_OFS_MAG2, 16'h7fff);
      wr(AMON_OFS_OFF2, 16'h0000);
      bus(1'b0, 32'h10, 32'h0, rd);
      chk("mag1 clamp", 32'h0000_2710, rd);
      repeat (3) @(posedge hclk);
      check_out();
    end
    chk("clip seen", 32'h1, 32'(nclip > 0));
    bus(1'b1, 32'h0000_0110, 32'h0000_0005, rd);
    bus(1'b1, 32'h0000_0024, 32'h0000_0005, rd);
    bus(1'b0, 32'h0000_0024, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    bus(1'b0, 32'h0000_0010, 32'h0, rd);
    chk("mag1 kept", 32'(16'(m_mag[0])), rd);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    reset_model();
    repeat (3) @(posedge hclk);
    check_out();
    bus(1'b0, 32'h0000_0014, 32'h0, rd);
    chk("mag2 default", 32'h0000_0064, rd);
    results();
  end
endmodule
